// file: verilog/serial_nv_memory_spi_port.sv
// Serial-bus target port of a byte-wide nonvolatile memory
//
// Notes on behaviour
// - Chip select high: output floats, inputs ignored; device in standby while pause is high.
// - Chip select low: act on serial clock edges, join the transfer.
// - Capture input on rising clock edge, change output on falling edge.
// - Clock from zero to 4 MHz, may stop; state kept meanwhile.
// - Pause low suspends operation, ignoring serial clock and chip select.
// - Write-guard low refuses status writes, never array writes.
// - Output driven only during reads; floats otherwise, also under pause.
// - Never drive output while receiving, so data lines may be tied.
// - Two address bytes, upper 3 bits ignored, 13 bits pick 8192 bytes.
// - Each byte committed on its eighth bit; no busy state.
// - Only an internal power-on reset brings the initial state.
// - Opcodes: arm 06, disarm 04, fetch 05, store 01, read 03, write 02.
// - All transfers in 8-bit groups, most significant bit first.
// - First byte after chip select fall is the only opcode.
// - Modes 0 and 3 only, told apart by clock level at select fall.
`timescale 1ns/1ps
`include "spi_nv_defs.svh"

module serial_nv_memory_spi_port #(
	parameter int ADDR_W = `ADDR_BITS,
	parameter int DEPTH = `MEM_DEPTH
) (
	// System clock and power-on reset
	input wire logic clk,
	input wire logic nrst,
	// Serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic hold_n,
	input wire logic wp_n,
	// Observed state, system clock domain
	output logic spi_mode3,
	output logic standby,
	output logic write_latch
);

	// ****************************************
	// Link domain state
	// ****************************************
	spi_nv_pkg::phase_e phase_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic is_read_reg;
	logic wel_reg;
	logic wr_done_reg;
	spi_nv_pkg::prot_s prot_reg;
	logic [6:0] tx_reg;
	logic ready_q1_reg;
	logic ready_q2_reg;
	logic [7:0] mem [0:DEPTH-1];

	logic frame_clr;
	logic out_clr;
	logic byte_end;
	logic [7:0] byte_in;
	logic [7:0] status_byte;
	logic [7:0] tx_byte;

	// ****************************************
	// System domain state
	// ****************************************
	logic ready_reg;
	logic cs_prev_reg;
	logic [3:0] sync_out;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic addr_locked(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		case (bp)
			`BP_NONE: hit = 1'b0;
			`BP_QUARTER: hit = (a >= ADDR_W'(`BP_QUARTER_BASE));
			`BP_HALF: hit = (a >= ADDR_W'(`BP_HALF_BASE));
			`BP_ALL: hit = 1'b1;
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction : addr_locked

	function automatic logic is_data_out(input spi_nv_pkg::phase_e ph);
		return (ph == spi_nv_pkg::PH_RD_DATA) || (ph == spi_nv_pkg::PH_STAT_RD);
	endfunction : is_data_out

	// Frame ends on select high, unless paused
	assign frame_clr = cs_n & hold_n;
	// Output released on select high or while paused
	assign out_clr = cs_n | ~hold_n;

	assign byte_end = (bit_cnt_reg == `BIT_LAST);
	assign byte_in = {rx_reg, si};

	assign status_byte = {prot_reg.wpen, 3'h0, prot_reg.bp, wel_reg, 1'h0};

	assign tx_byte = (phase_reg == spi_nv_pkg::PH_STAT_RD) ? status_byte : mem[addr_reg];

	// ****************************************
	// Bit and byte sequencing, rising edge
	// ****************************************
	always_ff @(posedge sck or posedge frame_clr) begin
		if (frame_clr) begin
			phase_reg <= spi_nv_pkg::PH_OPCODE;
			bit_cnt_reg <= `BIT_FIRST;
			rx_reg <= 7'h00;
		end else if (hold_n) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_reg <= byte_in[6:0];
			if (byte_end) begin
				case (phase_reg)
					spi_nv_pkg::PH_OPCODE: begin
						case (byte_in)
							`OP_MEM_READ: phase_reg <= spi_nv_pkg::PH_ADDR_HI;
							`OP_MEM_WRITE: phase_reg <= spi_nv_pkg::PH_ADDR_HI;
							`OP_STATUS_FETCH: phase_reg <= spi_nv_pkg::PH_STAT_RD;
							`OP_STATUS_STORE: phase_reg <= spi_nv_pkg::PH_STAT_WR;
							default: phase_reg <= spi_nv_pkg::PH_REST;
						endcase
					end
					spi_nv_pkg::PH_ADDR_HI: phase_reg <= spi_nv_pkg::PH_ADDR_LO;
					spi_nv_pkg::PH_ADDR_LO: begin
						phase_reg <= is_read_reg ? spi_nv_pkg::PH_RD_DATA : spi_nv_pkg::PH_WR_DATA;
					end
					spi_nv_pkg::PH_STAT_WR: phase_reg <= spi_nv_pkg::PH_REST;
					spi_nv_pkg::PH_WR_DATA: phase_reg <= spi_nv_pkg::PH_WR_DATA;
					spi_nv_pkg::PH_RD_DATA: phase_reg <= spi_nv_pkg::PH_RD_DATA;
					spi_nv_pkg::PH_STAT_RD: phase_reg <= spi_nv_pkg::PH_STAT_RD;
					spi_nv_pkg::PH_REST: phase_reg <= spi_nv_pkg::PH_REST;
					default: phase_reg <= spi_nv_pkg::PH_REST;
				endcase
			end
		end
	end

	// ****************************************
	// Address and direction, rising edge
	// ****************************************
	always_ff @(posedge sck) begin
		if (hold_n && !cs_n && byte_end) begin
			case (phase_reg)
				spi_nv_pkg::PH_OPCODE: is_read_reg <= (byte_in == `OP_MEM_READ);
				spi_nv_pkg::PH_ADDR_HI: begin
					addr_reg[ADDR_W-1:8] <= byte_in[`ADDR_HI_BITS-1:0];
				end
				spi_nv_pkg::PH_ADDR_LO: addr_reg[7:0] <= byte_in;
				spi_nv_pkg::PH_WR_DATA: addr_reg <= addr_reg + ADDR_W'(1);
				spi_nv_pkg::PH_RD_DATA: addr_reg <= addr_reg + ADDR_W'(1);
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// ****************************************
	// Power-on state into the link domain
	// ****************************************
	// Cleared at once by reset, so the first two sck edges after release clear the write latch and protection settings
	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			ready_q1_reg <= 1'b0;
			ready_q2_reg <= 1'b0;
		end else begin
			ready_q1_reg <= ready_reg;
			ready_q2_reg <= ready_q1_reg;
		end
	end

	// ****************************************
	// Write latch and protection settings
	// ****************************************
	always_ff @(posedge sck) begin
		if (!ready_q2_reg) begin
			wel_reg <= 1'b0;
			wr_done_reg <= 1'b0;
			prot_reg <= '0;
		end else if (hold_n && !cs_n) begin
			if (phase_reg == spi_nv_pkg::PH_OPCODE && bit_cnt_reg == `BIT_FIRST && wr_done_reg) begin
				wel_reg <= 1'b0;
				wr_done_reg <= 1'b0;
			end else if (byte_end) begin
				case (phase_reg)
					spi_nv_pkg::PH_OPCODE: begin
						if (byte_in == `OP_LATCH_ARM) begin
							wel_reg <= 1'b1;
						end else if (byte_in == `OP_LATCH_DISARM) begin
							wel_reg <= 1'b0;
						end
					end
					spi_nv_pkg::PH_STAT_WR: begin
						if (wel_reg && wp_n) begin
							prot_reg.wpen <= byte_in[`ST_WPEN];
							prot_reg.bp <= byte_in[`ST_BP_HI:`ST_BP_LO];
							wr_done_reg <= 1'b1;
						end
					end
					spi_nv_pkg::PH_WR_DATA: begin
						if (wel_reg) begin
							wr_done_reg <= 1'b1;
						end
					end
					default: wr_done_reg <= wr_done_reg;
				endcase
			end
		end
	end

	// ****************************************
	// Array write, committed on eighth bit
	// ****************************************
	always_ff @(posedge sck) begin
		if (hold_n && !cs_n && byte_end && phase_reg == spi_nv_pkg::PH_WR_DATA) begin
			if (wel_reg && !addr_locked(prot_reg.bp, addr_reg)) begin
				mem[addr_reg] <= byte_in;
			end
		end
	end

	// ****************************************
	// Serial output, falling edge
	// ****************************************
	always_ff @(negedge sck or posedge out_clr) begin
		if (out_clr) begin
			so_oe <= 1'b0;
		end else begin
			so_oe <= is_data_out(phase_reg);
		end
	end

	// Shift state survives a pause so the suspended bit resumes
	always_ff @(negedge sck or posedge frame_clr) begin
		if (frame_clr) begin
			so <= 1'b0;
			tx_reg <= 7'h00;
		end else if (hold_n && is_data_out(phase_reg)) begin
			if (bit_cnt_reg == `BIT_FIRST) begin
				so <= tx_byte[7];
				tx_reg <= tx_byte[6:0];
			end else begin
				so <= tx_reg[6];
				tx_reg <= {tx_reg[5:0], 1'b0};
			end
		end else if (hold_n) begin
			so <= 1'b0;
		end
	end

	// ****************************************
	// System domain: power-on ready
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= 1'b1;
		end
	end

	// ****************************************
	// System domain: link observation
	// ****************************************
	pin_sync #(
		.WIDTH(4),
		.RESET_VAL(4'h9)
	) u_link_sync (
		.clk(clk),
		.nrst(nrst),
		.din({cs_n, sck, wel_reg, hold_n}),
		.dout(sync_out)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cs_prev_reg <= 1'b1;
			spi_mode3 <= 1'b0;
			standby <= 1'b1;
		end else begin
			cs_prev_reg <= sync_out[3];
			standby <= sync_out[3] & sync_out[0];
			if (cs_prev_reg && !sync_out[3]) begin
				spi_mode3 <= sync_out[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			write_latch <= 1'b0;
		end else begin
			write_latch <= sync_out[1];
		end
	end

endmodule : serial_nv_memory_spi_port

// file: pkg/spi_nv_defs.svh
// Constants of the serial nonvolatile memory port
`ifndef SPI_NV_DEFS_SVH
`define SPI_NV_DEFS_SVH

// ****************************************
// Opcodes
// ****************************************
`define OP_LATCH_ARM 8'h06
`define OP_LATCH_DISARM 8'h04
`define OP_STATUS_FETCH 8'h05
`define OP_STATUS_STORE 8'h01
`define OP_MEM_READ 8'h03
`define OP_MEM_WRITE 8'h02

// ****************************************
// Array geometry and framing
// ****************************************
`define ADDR_BITS 13
`define ADDR_HI_BITS 5
`define MEM_DEPTH 8192
`define BYTE_BITS 8
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define SCK_MAX_HZ 4000000

// ****************************************
// Status byte layout
// ****************************************
`define ST_WPEN 7
`define ST_BP_HI 3
`define ST_BP_LO 2
`define ST_WEL 1

// ****************************************
// Block protection
// ****************************************
`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2
`define BP_ALL 2'h3
`define BP_QUARTER_BASE 13'h1800
`define BP_HALF_BASE 13'h1000

`endif

// file: pkg/spi_nv_pkg.sv
// Types shared by the serial nonvolatile memory port
package spi_nv_pkg;

	// ****************************************
	// Transfer phase, one-hot
	// ****************************************
	typedef enum logic [7:0] {
		PH_OPCODE = 8'h01,
		PH_ADDR_HI = 8'h02,
		PH_ADDR_LO = 8'h04,
		PH_WR_DATA = 8'h08,
		PH_RD_DATA = 8'h10,
		PH_STAT_WR = 8'h20,
		PH_STAT_RD = 8'h40,
		PH_REST = 8'h80
	} phase_e;

	// ****************************************
	// Protection settings, cleared at power-on
	// ****************************************
	typedef struct packed {
		logic wpen;
		logic [1:0] bp;
	} prot_s;

endpackage : spi_nv_pkg

// file: verilog/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] q1_reg;
	logic [WIDTH-1:0] q2_reg;
	logic [WIDTH-1:0] q3_reg;
	logic [WIDTH-1:0] agree;

	assign agree = ~(q2_reg ^ q3_reg);

	// ****************************************
	// Stages
	// ****************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			q1_reg <= RESET_VAL;
			q2_reg <= RESET_VAL;
			q3_reg <= RESET_VAL;
		end else begin
			q1_reg <= din;
			q2_reg <= q1_reg;
			q3_reg <= q2_reg;
		end
	end

	// Change taken once stages two and three agree
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dout <= RESET_VAL;
		end else begin
			dout <= (dout & ~agree) | (q3_reg & agree);
		end
	end

endmodule : pin_sync

// file: tb/serial_nv_memory_spi_port_asserts.sv
// Port assertions of the serial memory port
`timescale 1ns/1ps

module serial_nv_memory_spi_port_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic so,
	input wire logic so_oe,
	input wire logic hold_n,
	// Observed state
	input wire logic spi_mode3,
	input wire logic standby,
	input wire logic write_latch
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_oe_deselect: assert property (cs_n |-> !so_oe)
		else $error("so_oe high while deselected");
	chk_oe_pause: assert property (!hold_n |-> !so_oe)
		else $error("so_oe high while paused");
	chk_standby_idle: assert property ((cs_n && hold_n) [*8] |-> standby)
		else $error("standby missing");
	chk_select_wake: assert property (!cs_n [*8] |-> !standby)
		else $error("standby while selected");
	chk_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !sck && $past(sck))
		else $error("so changed off a falling edge");
	chk_oe_start: assert property ($rose(so_oe) |-> !sck && $past(sck) && !cs_n && hold_n)
		else $error("so_oe rose out of place");
	chk_mode_steady: assert property (!cs_n [*8] ##1 !cs_n |-> $stable(spi_mode3))
		else $error("mode changed inside a frame");
	chk_latch_idle: assert property (cs_n [*8] ##1 cs_n |-> $stable(write_latch))
		else $error("latch changed while deselected");
	chk_reset_state: assert property (disable iff (1'b0) !nrst |=> standby && !write_latch && !spi_mode3)
		else $error("reset state wrong");
endmodule : serial_nv_memory_spi_port_chk

bind serial_nv_memory_spi_port serial_nv_memory_spi_port_chk chk_i (.clk(clk), .nrst(nrst), .sck(sck),
	.cs_n(cs_n), .so(so), .so_oe(so_oe), .hold_n(hold_n), .spi_mode3(spi_mode3), .standby(standby),
	.write_latch(write_latch));

// file: tb/spi_host_model.sv
// Host master model of the serial link
`timescale 1ns/1ps

module spi_host_model (
	// Serial link
	output logic sck,
	output logic cs_n,
	output logic si,
	output logic hold_n,
	input wire logic so,
	input wire logic so_oe
);
	logic oe_seen;
	logic oe_paused;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		hold_n = 1'b1;
		oe_seen = 1'b0;
		oe_paused = 1'b0;
	end

	// Edges while deselected
	task automatic idle();
		repeat (3) begin
			#16 sck = 1'b1;
			#16 sck = 1'b0;
		end
	endtask : idle

	// Idle level picks the mode
	task automatic start(input logic m3);
		#7 sck = m3;
		#16 cs_n = 1'b0;
		#16;
	endtask : start

	// One byte each way, optional pause before a bit
	task automatic xbyte(input logic [7:0] tx, input int pause_at, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = tx[i];
			#16;
			if (i == pause_at) begin
				hold_n = 1'b0;
				#16 sck = 1'b1;
				#16 sck = 1'b0;
				oe_paused = so_oe;
				#16 hold_n = 1'b1;
				#16;
			end
			sck = 1'b1;
			rx[i] = so;
			oe_seen = oe_seen | so_oe;
			#16;
		end
	endtask : xbyte

	// Clock back to idle level, data line inverted
	task automatic stop(input logic m3);
		sck = m3;
		#16 cs_n = 1'b1;
		si = ~si;
		#16;
	endtask : stop
endmodule : spi_host_model

// file: tb/serial_nv_memory_spi_port_bench.sv
// Self-checking bench of the serial memory port
`timescale 1ns/1ps
`include "spi_nv_defs.svh"

module serial_nv_memory_spi_port_bench;
	logic clk;
	logic nrst;
	logic wp_n;
	logic sck;
	logic cs_n;
	logic si;
	logic hold_n;
	logic so;
	logic so_oe;
	logic spi_mode3;
	logic standby;
	logic write_latch;
	int err_count;
	int total_checks;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	serial_nv_memory_spi_port dut (.clk(clk), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n), .spi_mode3(spi_mode3), .standby(standby),
		.write_latch(write_latch));
	spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

	task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_byte

	task automatic check_flag(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask : check_flag

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : finish_test

	task automatic settle();
		repeat (10) @(posedge clk);
	endtask : settle

	task automatic cmd(input logic [7:0] op);
		logic [7:0] x;
		host.start(1'b0);
		host.xbyte(op, -1, x);
		host.stop(1'b0);
	endtask : cmd

	task automatic sfr(input logic [7:0] op, input logic [7:0] d, output logic [7:0] r);
		logic [7:0] x;
		host.start(1'b0);
		host.xbyte(op, -1, x);
		host.xbyte(d, -1, r);
		host.stop(1'b0);
	endtask : sfr

	// Opcode, two address bytes, two data bytes
	task automatic mem(input logic m3, input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
		input int pb, output logic [15:0] r);
		logic [7:0] b [5];
		logic [7:0] x;
		b = '{op, a[15:8], a[7:0], d[15:8], d[7:0]};
		r = 16'h0000;
		host.start(m3);
		for (int k = 0; k < 5; k++) begin
			host.xbyte(b[k], (k == pb) ? 3 : -1, x);
			if (k > 2)
				r = {r[7:0], x};
		end
		host.stop(m3);
	endtask : mem

	task automatic t_reset();
		host.idle();
		settle();
		check_flag("standby", 1'b1, standby);
		check_flag("write_latch", 1'b0, write_latch);
		check_flag("so_oe", 1'b0, so_oe);
	endtask : t_reset

	task automatic t_latch();
		logic [7:0] x;
		host.start(1'b1);
		settle();
		check_flag("standby", 1'b0, standby);
		check_flag("spi_mode3", 1'b1, spi_mode3);
		host.xbyte(`OP_LATCH_ARM, -1, x);
		host.stop(1'b1);
		settle();
		check_flag("write_latch", 1'b1, write_latch);
		cmd(`OP_LATCH_DISARM);
		settle();
		check_flag("write_latch", 1'b0, write_latch);
	endtask : t_latch

	task automatic t_array();
		logic [15:0] r;
		@(posedge clk) wp_n <= 1'b0;
		cmd(`OP_LATCH_ARM);
		host.oe_seen = 1'b0;
		mem(1'b0, `OP_MEM_WRITE, 16'hE005, 16'hA53C, -1, r);
		check_flag("so_oe in write", 1'b0, host.oe_seen);
		check_flag("spi_mode3", 1'b0, spi_mode3);
		mem(1'b1, `OP_MEM_READ, 16'h0005, 16'h0000, -1, r);
		check_byte("read byte 0", 8'hA5, r[15:8]);
		check_byte("read byte 1", 8'h3C, r[7:0]);
		check_flag("write_latch", 1'b0, write_latch);
		@(posedge clk) wp_n <= 1'b1;
	endtask : t_array

	task automatic t_status();
		logic [7:0] r;
		@(posedge clk) wp_n <= 1'b0;
		cmd(`OP_LATCH_ARM);
		sfr(`OP_STATUS_STORE, 8'h8C, r);
		cmd(`OP_LATCH_DISARM);
		sfr(`OP_STATUS_FETCH, 8'h00, r);
		check_byte("status guarded", 8'h00, r);
		@(posedge clk) wp_n <= 1'b1;
		cmd(`OP_LATCH_ARM);
		sfr(`OP_STATUS_FETCH, 8'h00, r);
		check_byte("status latch", 8'h02, r);
		sfr(`OP_STATUS_STORE, 8'h8C, r);
		sfr(`OP_STATUS_FETCH, 8'h00, r);
		check_byte("status stored", 8'h8C, r);
		cmd(`OP_LATCH_ARM);
		sfr(`OP_STATUS_STORE, 8'h00, r);
	endtask : t_status

	task automatic t_pause();
		logic [15:0] r;
		cmd(`OP_LATCH_ARM);
		mem(1'b0, `OP_MEM_WRITE, 16'h1FFF, 16'h9617, 1, r);
		host.oe_paused = 1'b1;
		mem(1'b0, `OP_MEM_READ, 16'h1FFF, 16'h0000, 3, r);
		check_flag("so_oe in pause", 1'b0, host.oe_paused);
		check_byte("wrapped byte", 8'h17, r[7:0]);
		check_byte("paused read", 8'h96, r[15:8]);
		mem(1'b0, `OP_MEM_READ, 16'h1FFF, 16'h0000, -1, r);
		check_byte("paused write", 8'h96, r[15:8]);
	endtask : t_pause

	initial begin
		nrst = 1'b0;
		wp_n = 1'b1;
		err_count = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_latch();
		t_array();
		t_status();
		t_pause();
		finish_test();
	end
endmodule : serial_nv_memory_spi_port_bench
